// ### inc/flash_cmd_pkg.sv
// Shared constants, opcodes and command classes for the flash link
package flash_cmd_pkg;

   // ==========================================================
   // Timing
   localparam int CORE_PERIOD_NS = 8;
   localparam int LINK_HALF_NS   = 32;
   localparam int HALF_CYCLES    =
      (LINK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam logic [1:0] HALF_LAST = 2'(HALF_CYCLES - 1);

   // ==========================================================
   // Framing and buffering
   localparam logic [2:0] ADDR_NARROW = 3'h3;
   localparam logic [2:0] ADDR_WIDE   = 3'h4;
   localparam logic [2:0] ADDR_NONE   = 3'h0;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 9;
   localparam int MARK_BIT   = 8;

   // ==========================================================
   // Opcodes that always take a 32-bit address
   localparam logic [7:0] OP_READ_A32 = 8'h13, OP_FAST_A32 = 8'h0c,
      OP_DOR_A32 = 8'h3c, OP_QOR_A32 = 8'h6c, OP_DUAL_IO_READ_A32 = 8'hbc,
      OP_QUAD_IO_READ_A32 = 8'hec, OP_DDR_A32 = 8'hee, OP_PP_A32 = 8'h12,
      OP_QPP_A32 = 8'h34, OP_SE_A32 = 8'h21, OP_HBE_A32 = 8'h53,
      OP_BE_A32 = 8'hdc, OP_LBRD_A32 = 8'he0, OP_LOCK_A32 = 8'he1,
      OP_UNLOCK_A32 = 8'he2, OP_SPP_A32 = 8'he3;
   // Opcodes whose address width follows the volatile length bit
   localparam logic [7:0] OP_PARAM_RD = 8'h5a, OP_READ = 8'h03,
      OP_FAST = 8'h0b, OP_DOR = 8'h3b, OP_QOR = 8'h6b, OP_DUAL_IO_READ = 8'hbb,
      OP_QUAD_IO_READ = 8'heb, OP_DDR = 8'hed, OP_PP = 8'h02, OP_QPP = 8'h32,
      OP_SE = 8'h20, OP_HBE = 8'h52, OP_BE = 8'hd8, OP_REG_RD = 8'h65,
      OP_REG_WR = 8'h71, OP_SEC_ER = 8'h44, OP_SEC_PG = 8'h42,
      OP_SEC_RD = 8'h48, OP_LBRD = 8'h3d, OP_LOCK = 8'h36,
      OP_UNLOCK = 8'h39, OP_SPP = 8'hfb;
   // Address mode switches
   localparam logic [7:0] OP_ENTER_WIDE = 8'hb7, OP_EXIT_WIDE = 8'he9;

   // ==========================================================
   // Command classes
   typedef enum logic [2:0] {
      KIND_NONE   = 3'b000,
      KIND_READ   = 3'b001,
      KIND_PROG   = 3'b010,
      KIND_ERASE  = 3'b011,
      KIND_PROT   = 3'b100,
      KIND_REG    = 3'b101,
      KIND_SECURE = 3'b110,
      KIND_MODE   = 3'b111
   } cmd_kind_t;

   typedef struct packed {
      cmd_kind_t kind;
      logic      fixed32;
   } op_class_t;

   // Sort an opcode into its class and address rule
   function automatic op_class_t classify(input logic [7:0] op);
      op_class_t c;
      c.kind    = KIND_NONE;
      c.fixed32 = 1'b0;
      case (op)
         OP_READ_A32, OP_FAST_A32, OP_DOR_A32, OP_QOR_A32, OP_DUAL_IO_READ_A32,
         OP_QUAD_IO_READ_A32, OP_DDR_A32:
         begin
            c.kind    = KIND_READ;
            c.fixed32 = 1'b1;
         end
         OP_PP_A32, OP_QPP_A32:
         begin
            c.kind    = KIND_PROG;
            c.fixed32 = 1'b1;
         end
         OP_SE_A32, OP_HBE_A32, OP_BE_A32:
         begin
            c.kind    = KIND_ERASE;
            c.fixed32 = 1'b1;
         end
         OP_LBRD_A32, OP_LOCK_A32, OP_UNLOCK_A32, OP_SPP_A32:
         begin
            c.kind    = KIND_PROT;
            c.fixed32 = 1'b1;
         end
         OP_PARAM_RD, OP_READ, OP_FAST, OP_DOR, OP_QOR, OP_DUAL_IO_READ,
         OP_QUAD_IO_READ, OP_DDR: c.kind = KIND_READ;
         OP_PP, OP_QPP: c.kind = KIND_PROG;
         OP_SE, OP_HBE, OP_BE: c.kind = KIND_ERASE;
         OP_REG_RD, OP_REG_WR: c.kind = KIND_REG;
         OP_SEC_ER, OP_SEC_PG, OP_SEC_RD: c.kind = KIND_SECURE;
         OP_LBRD, OP_LOCK, OP_UNLOCK, OP_SPP: c.kind = KIND_PROT;
         OP_ENTER_WIDE, OP_EXIT_WIDE: c.kind = KIND_MODE;
         default: c.kind = KIND_NONE;
      endcase
      return c;
   endfunction : classify

endpackage : flash_cmd_pkg

// ### inc/flash_link_if.sv
// Serial flash link between host controller and device
`timescale 1ns/1ps
interface flash_link_if;

   // ==========================================================
   // Pins, with drive split per party
   logic       sel_n;
   logic       sck;
   logic [3:0] host_dq_out;
   logic [3:0] host_dq_oe;
   logic [3:0] dev_dq_out;
   logic [3:0] dev_dq_oe;
   logic [3:0] dq;
   logic       contention;

   // Resolved line level, pulled high when nobody drives
   assign dq = (host_dq_oe & host_dq_out)
             | (~host_dq_oe & dev_dq_oe & dev_dq_out)
             | (~host_dq_oe & ~dev_dq_oe);
   // Both parties driving one line at once
   assign contention = |(host_dq_oe & dev_dq_oe);

   modport host (output sel_n, sck, host_dq_out, host_dq_oe, input dq);
   modport dev  (input sel_n, sck, dq, output dev_dq_out, dev_dq_oe);

endinterface : flash_link_if

// ### rtl/stream_fifo.sv
// Synchronous valid/ready FIFO
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  logic             clk,
   input  logic             rst,
   input  logic             in_valid,
   output logic             in_ready,
   input  logic [WIDTH-1:0] in_data,
   output logic             out_valid,
   input  logic             out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic        full;
   logic        empty;

   // ==========================================================
   // Flags from the pointer pair, extra bit tells full from empty
   assign empty     = (st.wr == st.rd);
   assign full      = (st.wr[AW] != st.rd[AW])
                    && (st.wr[AW-1:0] == st.rd[AW-1:0]);
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = st.mem[st.rd[AW-1:0]];

   // Write, read and reset
   always_comb
   begin
      next_st = st;
      if (in_valid && !full)
      begin
         next_st.mem[st.wr[AW-1:0]] = in_data;
         next_st.wr = st.wr + 1'b1;
      end
      if (out_ready && !empty)
         next_st.rd = st.rd + 1'b1;
      if (rst)
      begin
         next_st.wr = '0;
         next_st.rd = '0;
      end
   end

   always_ff @(posedge clk)
      st <= next_st;

endmodule : stream_fifo

// ### rtl/flash_cmd_device.sv
// Device end: frames, checks and decodes serial flash commands
`timescale 1ns/1ps
module flash_cmd_device (
   flash_link_if.dev               link,
   input  logic                    core_clk,
   input  logic                    sys_rst,
   input  logic                    addr_len_default_bit,
   input  logic                    soft_rst,
   input  logic                    cmd_ready,
   output logic                    cmd_valid,
   output logic [7:0]              cmd_opcode,
   output flash_cmd_pkg::cmd_kind_t cmd_kind,
   output logic [31:0]             cmd_addr,
   output logic                    cmd_addr_wide,
   output logic                    addr_len_volatile_bit,
   output logic                    frame_rejected,
   output logic                    overflow
);

   typedef enum logic [1:0] {
      DEC_OPC  = 2'b00,
      DEC_ADDR = 2'b01,
      DEC_SKIP = 2'b10,
      DEC_EMIT = 2'b11
   } dec_t;

   // Link clock state: per-frame counter and the hand-over to core
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [6:0] shift;
   } frame_t;

   typedef struct packed {
      logic       bit_tgl;
      logic       byte_tgl;
      logic [7:0] byte_hold;
   } hand_t;

   typedef struct packed {
      logic                     link_rst;
      logic                     sel_s1;
      logic                     sel_s2;
      logic                     sel_d;
      logic                     bit_s1;
      logic                     bit_s2;
      logic                     bit_d;
      logic                     byte_s1;
      logic                     byte_s2;
      logic                     byte_d;
      logic [2:0]               frame_bits;
      logic                     pend_end;
      logic                     ovf_frame;
      logic                     push_valid;
      logic [8:0]               push_data;
      dec_t                     dec;
      logic [7:0]               opcode;
      flash_cmd_pkg::cmd_kind_t kind;
      logic [2:0]               need;
      logic [2:0]               got;
      logic [31:0]              addr;
      logic                     addr_bit;
      logic                     cmd_valid;
      logic                     rejected;
      logic                     overflow;
   } core_t;

   frame_t                  fr;
   frame_t                  next_fr;
   hand_t                   hd;
   hand_t                   next_hd;
   core_t                   st;
   core_t                   next_st;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic [8:0]              fifo_out_data;
   logic                    drain_ready;
   logic                    take;
   logic                    bit_ev;
   logic                    byte_ev;
   logic                    end_ev;
   flash_cmd_pkg::op_class_t cls;

   // ==========================================================
   // Link side, clocked by the host's serial clock
   // never drives lines, address phase only
   assign link.dev_dq_out = 4'h0;
   assign link.dev_dq_oe  = 4'h0;

   // Shift in one bit per rising edge, publish each whole byte
   always_comb
   begin
      next_fr         = fr;
      next_hd         = hd;
      next_fr.bit_cnt = fr.bit_cnt + 3'h1;
      next_fr.shift   = {fr.shift[5:0], link.dq[0]};
      next_hd.bit_tgl = ~hd.bit_tgl;
      if (fr.bit_cnt == 3'h7)
      begin
         next_hd.byte_hold = {fr.shift, link.dq[0]};
         next_hd.byte_tgl  = ~hd.byte_tgl;
      end
   end

   always_ff @(posedge link.sck or posedge link.sel_n)
      if (link.sel_n)
         fr <= '0;
      else
         fr <= next_fr;

   // Hand-over toggles, cleared only by the system reset
   always_ff @(posedge link.sck or posedge st.link_rst)
      if (st.link_rst)
         hd <= '0;
      else
         hd <= next_hd;

   // ==========================================================
   // Byte buffer between link capture and decoder
   stream_fifo #(
      .WIDTH (flash_cmd_pkg::FIFO_WIDTH),
      .DEPTH (flash_cmd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (core_clk),
      .rst       (sys_rst),
      .in_valid  (st.push_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (st.push_data),
      .out_valid (fifo_out_valid),
      .out_ready (drain_ready),
      .out_data  (fifo_out_data)
   );

   // A pending command stalls the drain
   assign drain_ready = (st.dec != DEC_EMIT);
   assign take        = fifo_out_valid && drain_ready;
   assign bit_ev      = (st.bit_s2 != st.bit_d);
   assign byte_ev     = (st.byte_s2 != st.byte_d);
   assign end_ev      = st.sel_s2 && !st.sel_d;
   assign cls         = flash_cmd_pkg::classify(fifo_out_data[7:0]);

   // ==========================================================
   // Core side: crossings, framing and decode
   always_comb
   begin
      next_st            = st;
      next_st.link_rst   = sys_rst;
      next_st.sel_s1     = link.sel_n;
      next_st.sel_s2     = st.sel_s1;
      next_st.sel_d      = st.sel_s2;
      next_st.bit_s1     = hd.bit_tgl;
      next_st.bit_s2     = st.bit_s1;
      next_st.bit_d      = st.bit_s2;
      next_st.byte_s1    = hd.byte_tgl;
      next_st.byte_s2    = st.byte_s1;
      next_st.byte_d     = st.byte_s2;
      next_st.push_valid = 1'b0;
      next_st.rejected   = 1'b0;
      next_st.overflow   = 1'b0;
      // A word refused by a full buffer spoils its frame
      if (st.push_valid && !fifo_in_ready)
      begin
         next_st.ovf_frame = 1'b1;
         next_st.overflow  = 1'b1;
      end
      // count bits of the frame modulo eight
      if (bit_ev)
         next_st.frame_bits = st.frame_bits + 3'h1;
      if (byte_ev)
      begin
         next_st.push_valid = 1'b1;
         next_st.push_data  = {1'b0, hd.byte_hold};
      end
      if (end_ev || st.pend_end)
      begin
         next_st.pend_end = byte_ev;
         if (!byte_ev)
         begin
            // End marker, bit zero tells a clean byte boundary
            next_st.push_valid = 1'b1;
            next_st.push_data  = {1'b1, 7'h00,
               (st.frame_bits == 3'h0) && !st.ovf_frame};
            next_st.frame_bits = 3'h0;
            next_st.ovf_frame  = 1'b0;
         end
      end
      // Decoder, driven by buffered bytes and end markers
      case (st.dec)
         DEC_OPC:
            if (take && fifo_out_data[flash_cmd_pkg::MARK_BIT])
               next_st.rejected = !fifo_out_data[0];
            else if (take)
            begin
               next_st.opcode = fifo_out_data[7:0];
               next_st.kind   = cls.kind;
               next_st.got    = 3'h0;
               next_st.addr   = 32'h0;
               if (cls.kind == flash_cmd_pkg::KIND_MODE)
                  next_st.need = flash_cmd_pkg::ADDR_NONE;
               else if (cls.fixed32 || st.addr_bit)
                  next_st.need = flash_cmd_pkg::ADDR_WIDE;
               else
                  next_st.need = flash_cmd_pkg::ADDR_NARROW;
               // opcodes without a class are not decoded, skipped to the end marker
               if (cls.kind == flash_cmd_pkg::KIND_NONE)
                  next_st.dec = DEC_SKIP;
               else
                  next_st.dec = DEC_ADDR;
            end
         DEC_ADDR:
            if (take && fifo_out_data[flash_cmd_pkg::MARK_BIT])
            begin
               next_st.dec = DEC_OPC;
               // misaligned or short frame is refused
               if (!fifo_out_data[0] || st.got != st.need)
                  next_st.rejected = 1'b1;
               else if (st.kind == flash_cmd_pkg::KIND_MODE)
                  next_st.addr_bit =
                     (st.opcode == flash_cmd_pkg::OP_ENTER_WIDE);
               else
               begin
                  next_st.cmd_valid = 1'b1;
                  next_st.dec       = DEC_EMIT;
               end
            end
            else if (take && st.got != st.need)
            begin
               next_st.addr = {st.addr[23:0], fifo_out_data[7:0]};
               next_st.got  = st.got + 3'h1;
            end
         DEC_SKIP:
            if (take && fifo_out_data[flash_cmd_pkg::MARK_BIT])
               next_st.dec = DEC_OPC;
         DEC_EMIT:
            if (cmd_ready)
            begin
               next_st.cmd_valid = 1'b0;
               next_st.dec       = DEC_OPC;
            end
         default: next_st.dec = DEC_OPC;
      endcase
      // software reset reloads the length bit
      if (soft_rst)
         next_st.addr_bit = addr_len_default_bit;
      if (sys_rst)
      begin
         next_st          = '0;
         next_st.link_rst = 1'b1;
         next_st.sel_s1   = 1'b1;
         next_st.sel_s2   = 1'b1;
         next_st.sel_d    = 1'b1;
         next_st.addr_bit = addr_len_default_bit;
      end
   end

   // volatile length bit held in core state
   always_ff @(posedge core_clk)
      st <= next_st;

   // Outputs straight from core state
   assign cmd_valid             = st.cmd_valid;
   assign cmd_opcode            = st.opcode;
   assign cmd_kind              = st.kind;
   assign cmd_addr              = st.addr;
   assign cmd_addr_wide         = (st.need == flash_cmd_pkg::ADDR_WIDE);
   assign addr_len_volatile_bit = st.addr_bit;
   assign frame_rejected        = st.rejected;
   assign overflow              = st.overflow;

endmodule : flash_cmd_device

// ### rtl/flash_cmd_host.sv
// Host end: drives select, serial clock and serial input
`timescale 1ns/1ps
module flash_cmd_host (
   flash_link_if.host link,
   input  logic       core_clk,
   input  logic       sys_rst,
   input  logic       req_valid,
   input  logic [7:0] req_byte,
   input  logic [3:0] req_bits,
   input  logic       req_last,
   output logic       req_ready,
   output logic       frame_done
);

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW  = 3'b001,
      H_HIGH = 3'b010,
      H_NEXT = 3'b011,
      H_GAP  = 3'b100
   } host_state_t;

   typedef struct packed {
      host_state_t state;
      logic [1:0]  div;
      logic        sel_n;
      logic        sck;
      logic [7:0]  shift;
      logic [3:0]  bits_left;
      logic        last;
      logic        oe;
      logic        ready;
      logic        done;
   } host_t;

   host_t st;
   host_t next_st;
   logic  half_done;

   // Take one request byte into the shifter
   function automatic host_t load_byte(input host_t s,
                                       input logic [7:0] b,
                                       input logic [3:0] n,
                                       input logic l);
      host_t r;
      r           = s;
      r.shift     = b;
      r.bits_left = n;
      r.last      = l;
      r.ready     = 1'b0;
      r.div       = 2'h0;
      r.state     = H_LOW;
      return r;
   endfunction : load_byte

   // ==========================================================
   // Pins straight from state; only the serial input is driven
   assign link.sel_n       = st.sel_n;
   assign link.sck         = st.sck;
   assign link.host_dq_out = {3'h0, st.shift[7]};
   // host drives only its serial input
   assign link.host_dq_oe  = {3'h0, st.oe};
   assign req_ready        = st.ready;
   assign frame_done       = st.done;
   assign half_done        = (st.div == flash_cmd_pkg::HALF_LAST);

   // Divider and bit sequencing, MSB first, data moves on low clock
   always_comb
   begin
      next_st      = st;
      next_st.done = 1'b0;
      next_st.div  = st.div + 2'h1;
      case (st.state)
         H_IDLE:
         begin
            next_st.div = 2'h0;
            // select falls a half period before first edge
            if (req_valid && st.ready)
            begin
               next_st       = load_byte(st, req_byte, req_bits,
                                         req_last);
               next_st.sel_n = 1'b0;
               next_st.oe    = 1'b1;
            end
         end
         H_LOW:
            if (half_done)
            begin
               next_st.sck   = 1'b1;
               next_st.div   = 2'h0;
               next_st.state = H_HIGH;
            end
         H_HIGH:
            if (half_done)
            begin
               next_st.sck = 1'b0;
               next_st.div = 2'h0;
               if (st.bits_left > 4'h1)
               begin
                  next_st.bits_left = st.bits_left - 4'h1;
                  next_st.shift     = {st.shift[6:0], 1'b0};
                  next_st.state     = H_LOW;
               end
               else if (st.last)
                  next_st.state = H_GAP;
               else
               begin
                  next_st.ready = 1'b1;
                  next_st.state = H_NEXT;
               end
            end
         H_NEXT:
         begin
            next_st.div = 2'h0;
            if (req_valid && st.ready)
               next_st = load_byte(st, req_byte, req_bits, req_last);
         end
         H_GAP:
            if (half_done)
            begin
               next_st.div = 2'h0;
               if (st.sel_n)
               begin
                  next_st.done  = 1'b1;
                  next_st.ready = 1'b1;
                  next_st.state = H_IDLE;
               end
               else
               begin
                  next_st.sel_n = 1'b1;
                  next_st.oe    = 1'b0;
               end
            end
         default: next_st.state = H_IDLE;
      endcase
      if (sys_rst)
      begin
         next_st       = '0;
         next_st.sel_n = 1'b1;
         next_st.ready = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
      st <= next_st;

endmodule : flash_cmd_host

// ### test/flash_link_checker.sv
// Pin timing checks on the link between both ends
`timescale 1ns/1ps
module flash_link_checker (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       sel_n,
   input wire logic       sck,
   input wire logic [3:0] host_dq_oe,
   input wire logic [3:0] dev_dq_oe,
   input wire logic       contention
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Line ownership
   dev_silent_a: assert property (dev_dq_oe == 4'h0)
      else $error("device drove a data line");
   no_clash_a: assert property (!contention)
      else $error("both ends drove a data line");
   oe_follow_a: assert property (host_dq_oe == {3'h0, !sel_n})
      else $error("host drive not tied to select");
   // ==========================================
   // Framing and clock shape
   sck_idle_a: assert property (sel_n |-> !sck)
      else $error("clock moved while deselected");
   sel_lead_a: assert property ($fell(sel_n) |-> !sck [*4] ##1 sck)
      else $error("select lead time wrong");
   sel_lag_a: assert property ($rose(sel_n) |-> !$past(sck, 4))
      else $error("select rose too soon");
   sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
      else $error("clock high time wrong");
   rise_sel_a: assert property ($rose(sck) |-> !$past(sel_n, 4))
      else $error("clock rose without select");
endmodule : flash_link_checker

// ### test/spi_flash_cmd_frame_addr_len_test.sv
// Self-checking bench with host and device ends joined by the link
`timescale 1ns/1ps
module spi_flash_cmd_frame_addr_len_test;
   logic        core_clk = 0, sys_rst = 1, req_valid = 0, req_last = 0;
   logic        def_bit = 0, soft_rst = 0, cmd_ready = 1;
   logic        req_ready, frame_done, cmd_valid, cmd_addr_wide, addr_bit;
   logic        rej, ovf, cap_wide;
   logic [7:0]  req_byte = 8'h00, cmd_opcode, cap_op;
   logic [3:0]  req_bits = 4'h8;
   logic [2:0]  cap_kind;
   logic [31:0] cmd_addr, cap_addr;
   flash_cmd_pkg::cmd_kind_t cmd_kind;
   int bad_count = 0, n_checks = 0, n_cmd, n_rej, n_ovf = 0, cycles = 0;
   // Row: wide flag and expected class, then opcode
   localparam logic [11:0] ROWS [38] = '{12'h913, 12'h90c, 12'h93c,
      12'h96c, 12'h9bc, 12'h9ec, 12'h9ee, 12'ha12, 12'ha34, 12'hb21,
      12'hb53, 12'hbdc, 12'hce0, 12'hce1, 12'hce2, 12'hce3, 12'h15a,
      12'h103, 12'h10b, 12'h13b, 12'h16b, 12'h1bb, 12'h1eb, 12'h1ed,
      12'h202, 12'h232, 12'h320, 12'h352, 12'h3d8, 12'h565, 12'h571,
      12'h644, 12'h642, 12'h648, 12'h43d, 12'h436, 12'h439, 12'h4fb};
   flash_link_if link ();
   flash_cmd_host u_flash_cmd_host (.link(link.host), .core_clk, .sys_rst,
      .req_valid, .req_byte, .req_bits, .req_last, .req_ready, .frame_done);
   flash_cmd_device u_flash_cmd_device (.link(link.dev), .core_clk,
      .sys_rst, .addr_len_default_bit(def_bit), .soft_rst, .cmd_ready,
      .cmd_valid, .cmd_opcode, .cmd_kind, .cmd_addr, .cmd_addr_wide,
      .addr_len_volatile_bit(addr_bit), .frame_rejected(rej),
      .overflow(ovf));
   flash_link_checker u_flash_link_checker (.core_clk, .sys_rst,
      .sel_n(link.sel_n), .sck(link.sck), .host_dq_oe(link.host_dq_oe),
      .dev_dq_oe(link.dev_dq_oe), .contention(link.contention));
   initial forever #4 core_clk = ~core_clk;
   // ==========================================
   // Capture device answers, cut a hang short
   always @(posedge core_clk)
   begin
      cycles++;
      if (cmd_valid === 1'b1 && cmd_ready)
      begin
         n_cmd++;
         cap_op = cmd_opcode;
         cap_kind = cmd_kind;
         cap_addr = cmd_addr;
         cap_wide = cmd_addr_wide;
      end
      if (rej === 1'b1) n_rej++;
      if (ovf === 1'b1) n_ovf++;
      if (cycles == 60000)
      begin
         bad_count++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One byte to the host port; a last byte waits for frame end
   task automatic send(input logic [7:0] b, input logic [3:0] n,
                       input logic l);
      @(negedge core_clk);
      req_valid = 1;
      req_byte = b;
      req_bits = n;
      req_last = l;
      do @(posedge core_clk); while (req_ready !== 1'b1);
      @(negedge core_clk);
      req_valid = 0;
      if (l)
      begin
         do @(posedge core_clk); while (frame_done !== 1'b1);
         repeat (16) @(posedge core_clk);
      end
   endtask : send
   task automatic frame(input logic [7:0] op, input int n);
      n_cmd = 0;
      n_rej = 0;
      send(op, 4'h8, n == 0);
      for (int i = 1; i <= n; i++)
         send(8'(17 * i), 4'h8, i == n);
   endtask : frame
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // ==========================================
   // Main sequence
   initial
   begin
      logic w;
      repeat (16) @(negedge core_clk);
      sys_rst = 0;
      chk(cmd_valid, 0);
      chk(addr_bit, def_bit);
      for (int p = 0; p < 2; p++)
      begin
         foreach (ROWS[r])
         begin
            w = ROWS[r][11] | p[0];
            frame(ROWS[r][7:0], w ? 4 : 3);
            chk(n_cmd, 1);
            chk(cap_op, ROWS[r][7:0]);
            chk(cap_kind, ROWS[r][10:8]);
            chk(cap_addr, w ? 32'h11223344 : 32'h00112233);
            chk(cap_wide, w);
         end
         frame(8'hb7, 0);
         chk(addr_bit, 1);
      end
      frame(8'h02, 3);
      chk(n_cmd * 16 + n_rej, 1);
      n_rej = 0;
      send(8'he9, 4'h8, 0);
      send(8'h00, 4'h3, 1);
      chk(n_rej * 2 + addr_bit, 3);
      frame(8'h9f, 4);
      chk(n_cmd * 16 + n_rej, 0);
      frame(8'he9, 0);
      chk(addr_bit, 0);
      @(negedge core_clk);
      def_bit = 1;
      soft_rst = 1;
      @(negedge core_clk);
      soft_rst = 0;
      repeat (4) @(negedge core_clk);
      chk(addr_bit, 1);
      def_bit = 0;
      sys_rst = 1;
      repeat (4) @(negedge core_clk);
      sys_rst = 0;
      chk(addr_bit, 0);
      cmd_ready = 0;
      frame(8'h03, 3);
      frame(8'h0b, 12);
      cmd_ready = 1;
      repeat (20) @(negedge core_clk);
      chk(n_ovf > 0, 1);
      complete_run();
   end
endmodule : spi_flash_cmd_frame_addr_len_test
